// ===== design/mbw_map.svh
`ifndef MBW_MAP_SVH
`define MBW_MAP_SVH

// Function codes served by the handler, and the bit that marks an exception answer.
`define MBW_FC_DIAG 8'h08
`define MBW_FC_WR_ONE 8'h06
`define MBW_FC_WR_RAM 8'h41
`define MBW_FC_WR_BLK 8'h10
`define MBW_FC_ERR_BIT 8'h80

// Diagnosis sub-functions.
`define MBW_SUB_ECHO 16'h0000
`define MBW_SUB_CLR_CNT 16'h000A

// Exception codes.
`define MBW_EXC_NONE 8'h00
`define MBW_EXC_FUNC 8'h01
`define MBW_EXC_VALUE 8'h03

// Frame layout: byte positions and lengths.
`define MBW_POS_FC 8'h00
`define MBW_POS_F1_HI 8'h01
`define MBW_POS_F1_LO 8'h02
`define MBW_POS_F2_HI 8'h03
`define MBW_POS_F2_LO 8'h04
`define MBW_POS_BC 8'h05
`define MBW_LEN_FIXED 8'h05
`define MBW_LEN_BLK_HDR 8'h06
`define MBW_MAX_REGS 16'h0010
`define MBW_LEN_MAX 8'hFF

// Last byte index of a normal and of an exception answer.
`define MBW_TX_LAST_OK 3'h4
`define MBW_TX_LAST_EXC 3'h1

// Reset values.
`define MBW_RST_BYTE 8'h00
`define MBW_RST_WORD 16'h0000

`endif

// ===== design/mbw_pkg.sv
package mbw_pkg;

  typedef enum logic [5:0] {
    MBW_RX = 6'h01,
    MBW_CHK = 6'h02,
    MBW_SEL = 6'h04,
    MBW_LOAD = 6'h08,
    MBW_WAIT = 6'h10,
    MBW_TX = 6'h20
  } mbw_state_e_t;

  typedef struct packed {
    mbw_state_e_t st;
    logic [7:0] idx;
    logic [7:0] fc;
    logic [15:0] f1;
    logic [15:0] f2;
    logic [7:0] bc;
    logic [7:0] hi;
    logic ovf;
    logic [4:0] wi;
    logic [7:0] exc;
    logic [2:0] txi;
    logic [15:0] err_cnt;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
    logic wr_req;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
    logic wr_save;
    logic buf_we;
    logic [3:0] buf_waddr;
    logic [15:0] buf_wdata;
    logic [3:0] buf_raddr;
  } mbw_regs_t;

endpackage

// ===== design/mbw_buf_if.sv
`timescale 1ns/1ps
`default_nettype none

interface mbw_buf_if;
  logic we;
  logic [3:0] waddr;
  logic [15:0] wdata;
  logic [3:0] raddr;
  logic [15:0] rdata;

  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

`default_nettype wire

// ===== design/mbw_regbuf.sv
`timescale 1ns/1ps
`default_nettype none
`include "mbw_map.svh"

// Holds the values of a block write until the whole frame has been checked.
module mbw_regbuf (
  input wire logic clk_i,
  input wire logic nrst_i,
  mbw_buf_if.mem bus
);
  logic [15:0] mem [16];
  logic [15:0] rdata;

  always_ff @(posedge clk_i) begin
    if (bus.we) begin
      mem[bus.waddr] <= bus.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata <= `MBW_RST_WORD;
    end else begin
      rdata <= mem[bus.raddr];
    end
  end

  assign bus.rdata = rdata;
endmodule

`default_nettype wire

// ===== design/mbw_handler.sv
`timescale 1ns/1ps
`default_nettype none
`include "mbw_map.svh"

module mbw_handler (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_last_i,
  input wire logic rx_err_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  output logic wr_req_o,
  output logic [15:0] wr_addr_o,
  output logic [15:0] wr_data_o,
  output logic wr_save_o,
  input wire logic wr_done_i,
  input wire logic [7:0] wr_exc_i,
  input wire logic run_lock_i,
  output logic [15:0] err_cnt_o
);
  mbw_pkg::mbw_regs_t r;
  mbw_pkg::mbw_regs_t next_r;
  mbw_buf_if bufc ();

  mbw_regbuf u_buf (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .bus(bufc.mem)
  );

  assign bufc.we = r.buf_we;
  assign bufc.waddr = r.buf_waddr;
  assign bufc.wdata = r.buf_wdata;
  assign bufc.raddr = r.buf_raddr;

  // Every normal answer is the function code followed by the two 16-bit fields.
  function automatic logic [7:0] resp_byte(input mbw_pkg::mbw_regs_t s, input logic [2:0] i);
    logic [7:0] b;
    b = s.fc;
    if (s.exc != `MBW_EXC_NONE) begin
      if (i == 3'h0) begin
        b = s.fc | `MBW_FC_ERR_BIT;
      end else begin
        b = s.exc;
      end
    end else begin
      unique case (i)
        3'h0: b = s.fc;
        3'h1: b = s.f1[15:8];
        3'h2: b = s.f1[7:0];
        3'h3: b = s.f2[15:8];
        default: b = s.f2[7:0];
      endcase
    end
    return b;
  endfunction

  function automatic logic [2:0] resp_last(input mbw_pkg::mbw_regs_t s);
    return (s.exc != `MBW_EXC_NONE) ? `MBW_TX_LAST_EXC : `MBW_TX_LAST_OK;
  endfunction

  always_comb begin
    logic fail;
    logic clr_cnt;
    logic [7:0] pay;
    fail = 1'b0;
    clr_cnt = 1'b0;
    pay = r.idx - `MBW_LEN_BLK_HDR;
    next_r = r;
    next_r.buf_we = 1'b0;

    unique case (r.st)
      mbw_pkg::MBW_RX: begin
        // Bytes are only taken here; anything arriving while busy is dropped.
        if (rx_valid_i) begin
          if (r.idx == `MBW_LEN_MAX) begin
            next_r.ovf = 1'b1;
          end else begin
            next_r.idx = r.idx + 8'h01;
          end
          unique case (r.idx)
            `MBW_POS_FC: next_r.fc = rx_data_i;
            `MBW_POS_F1_HI: next_r.f1[15:8] = rx_data_i;
            `MBW_POS_F1_LO: next_r.f1[7:0] = rx_data_i;
            `MBW_POS_F2_HI: next_r.f2[15:8] = rx_data_i;
            `MBW_POS_F2_LO: next_r.f2[7:0] = rx_data_i;
            `MBW_POS_BC: next_r.bc = rx_data_i;
            default: begin
              if (!pay[0]) begin
                next_r.hi = rx_data_i;
              end else if (pay[7:5] != 3'h0) begin
                next_r.ovf = 1'b1;
              end else begin
                next_r.buf_we = 1'b1;
                next_r.buf_waddr = pay[4:1];
                next_r.buf_wdata = {r.hi, rx_data_i};
              end
            end
          endcase
          if (rx_last_i) begin
            next_r.st = mbw_pkg::MBW_CHK;
          end
        end
      end
      mbw_pkg::MBW_CHK: begin
        next_r.exc = `MBW_EXC_NONE;
        next_r.wi = 5'h00;
        next_r.txi = 3'h0;
        next_r.buf_raddr = 4'h0;
        next_r.st = mbw_pkg::MBW_SEL;
        unique case (r.fc)
          `MBW_FC_DIAG: begin
            // Diagnosis never reaches the write port.
            next_r.st = mbw_pkg::MBW_TX;
            if (r.idx != `MBW_LEN_FIXED) begin
              next_r.exc = `MBW_EXC_VALUE;
            end else if (r.f1 == `MBW_SUB_CLR_CNT) begin
              clr_cnt = 1'b1;
            end else if (r.f1 != `MBW_SUB_ECHO) begin
              next_r.exc = `MBW_EXC_FUNC;
            end
          end
          `MBW_FC_WR_ONE, `MBW_FC_WR_RAM: begin
            if (r.idx != `MBW_LEN_FIXED) begin
              next_r.exc = `MBW_EXC_VALUE;
            end
          end
          `MBW_FC_WR_BLK: begin
            if (r.ovf || r.f2 == `MBW_RST_WORD || r.f2 > `MBW_MAX_REGS ||
                {8'h00, r.bc} != {r.f2[14:0], 1'b0} ||
                r.idx != `MBW_LEN_BLK_HDR + r.bc) begin
              next_r.exc = `MBW_EXC_VALUE;
            end
          end
          default: next_r.exc = `MBW_EXC_FUNC;
        endcase
        if (next_r.exc != `MBW_EXC_NONE) begin
          next_r.st = mbw_pkg::MBW_TX;
        end
        if (next_r.st == mbw_pkg::MBW_TX) begin
          next_r.tx_valid = 1'b1;
          next_r.tx_data = resp_byte(next_r, 3'h0);
          next_r.tx_last = 1'b0;
        end
      end
      mbw_pkg::MBW_SEL: begin
        // The read address was set one cycle earlier, so the registered word is ready in LOAD.
        next_r.st = mbw_pkg::MBW_LOAD;
      end
      mbw_pkg::MBW_LOAD: begin
        next_r.wr_req = 1'b1;
        next_r.wr_save = (r.fc != `MBW_FC_WR_RAM);
        next_r.wr_addr = r.f1 + {11'h000, r.wi};
        next_r.wr_data = (r.fc == `MBW_FC_WR_BLK) ? bufc.rdata : r.f2;
        next_r.st = mbw_pkg::MBW_WAIT;
      end
      mbw_pkg::MBW_WAIT: begin
        if (r.fc == `MBW_FC_WR_RAM && run_lock_i) begin
          next_r.wr_req = 1'b0;
          next_r.exc = `MBW_EXC_FUNC;
          fail = 1'b1;
        end else if (wr_done_i) begin
          next_r.wr_req = 1'b0;
          next_r.wi = r.wi + 5'h01;
          if (wr_exc_i != `MBW_EXC_NONE) begin
            next_r.exc = wr_exc_i;
            fail = 1'b1;
          end else if (r.fc == `MBW_FC_WR_BLK && {11'h000, next_r.wi} < r.f2) begin
            next_r.buf_raddr = next_r.wi[3:0];
            next_r.st = mbw_pkg::MBW_SEL;
          end else begin
            fail = 1'b1;
          end
        end
        if (fail) begin
          next_r.st = mbw_pkg::MBW_TX;
          next_r.tx_valid = 1'b1;
          next_r.tx_data = resp_byte(next_r, 3'h0);
          next_r.tx_last = 1'b0;
        end
      end
      mbw_pkg::MBW_TX: begin
        if (tx_ready_i) begin
          if (r.tx_last) begin
            next_r.tx_valid = 1'b0;
            next_r.tx_last = 1'b0;
            next_r.idx = `MBW_RST_BYTE;
            next_r.ovf = 1'b0;
            next_r.st = mbw_pkg::MBW_RX;
          end else begin
            next_r.txi = r.txi + 3'h1;
            next_r.tx_data = resp_byte(r, next_r.txi);
            next_r.tx_last = (next_r.txi == resp_last(r));
          end
        end
      end
    endcase

    // Counting wins over clearing so an error in the clearing cycle is kept.
    if (clr_cnt) begin
      next_r.err_cnt = `MBW_RST_WORD;
    end
    if ((rx_err_i || (r.st == mbw_pkg::MBW_CHK && next_r.exc != `MBW_EXC_NONE) ||
         (r.st == mbw_pkg::MBW_WAIT && fail && next_r.exc != `MBW_EXC_NONE)) &&
        next_r.err_cnt != 16'hFFFF) begin
      next_r.err_cnt = next_r.err_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
      r.st <= mbw_pkg::MBW_RX;
    end else begin
      r <= next_r;
    end
  end

  assign tx_valid_o = r.tx_valid;
  assign tx_data_o = r.tx_data;
  assign tx_last_o = r.tx_last;
  assign wr_req_o = r.wr_req;
  assign wr_addr_o = r.wr_addr;
  assign wr_data_o = r.wr_data;
  assign wr_save_o = r.wr_save;
  assign err_cnt_o = r.err_cnt;
endmodule

`default_nettype wire

// ===== tb/mbw_handler_props.sv
`timescale 1ns/1ps
`default_nettype none
module mbw_handler_props (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic rx_err_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic wr_req_o,
  input wire logic [15:0] wr_addr_o,
  input wire logic [15:0] wr_data_o,
  input wire logic wr_save_o,
  input wire logic wr_done_i,
  input wire logic [7:0] wr_exc_i,
  input wire logic run_lock_i,
  input wire logic [15:0] err_cnt_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic [2:0] n;
  logic e7;
  wire logic take = tx_valid_o && tx_ready_i;
  // The first byte's top bit tells an exception answer from a normal one.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      n <= 3'h0;
      e7 <= 1'b0;
    end else if (take) begin
      n <= tx_last_o ? 3'h0 : n + 3'h1;
      if (n == 3'h0) e7 <= tx_data_o[7];
    end
  end
  a_tx_holds: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o &&
    $stable({tx_data_o, tx_last_o})) else $error("answer byte changed before taken");
  a_answer_length: assert property (take && tx_last_o |-> n == (e7 ? 3'h1 : 3'h4))
    else $error("answer length wrong");
  a_req_holds: assert property (wr_req_o && !wr_done_i && !run_lock_i |=> wr_req_o &&
    $stable({wr_addr_o, wr_data_o, wr_save_o})) else $error("write request changed");
  a_quiet_write: assert property (wr_req_o |-> !tx_valid_o)
    else $error("answer before write done");
  a_done_answers: assert property (wr_req_o && wr_done_i && wr_exc_i != 8'h00 |=>
    tx_valid_o && tx_data_o[7]) else $error("write failure not answered");
  a_lock_refused: assert property (wr_req_o && !wr_save_o && run_lock_i |=>
    !wr_req_o ##[0:3] tx_valid_o && tx_data_o == 8'hC1) else $error("locked write kept");
  a_err_counts: assert property (rx_err_i |=> err_cnt_o != 16'h0000)
    else $error("link error not counted");
  a_count_steps: assert property ($changed(err_cnt_o) |->
    (err_cnt_o == $past(err_cnt_o) + 16'h0001) || (err_cnt_o <= 16'h0001))
    else $error("error count jumped");
endmodule
bind mbw_handler mbw_handler_props u_props (.clk_i, .nrst_i, .rx_err_i, .tx_valid_o,
  .tx_data_o, .tx_last_o, .tx_ready_i, .wr_req_o, .wr_addr_o, .wr_data_o, .wr_save_o,
  .wr_done_i, .wr_exc_i, .run_lock_i, .err_cnt_o);
`default_nettype wire

// ===== tb/mbw_app_model.sv
`timescale 1ns/1ps
`default_nettype none
module mbw_app_model (
  input wire logic clk_i,
  input wire logic wr_req_i,
  input wire logic [15:0] wr_addr_i,
  input wire logic wr_save_i,
  output logic wr_done_o,
  output logic [7:0] wr_exc_o,
  output logic run_lock_o
);
  // Top nibble F is run-locked; E makes the application refuse the write.
  assign run_lock_o = wr_req_i && wr_addr_i[15:12] == 4'hF;
  initial begin
    wr_done_o = 1'b0;
    wr_exc_o = 8'h00;
    forever begin
      @(posedge clk_i);
      if (wr_req_i && !(run_lock_o && !wr_save_i)) begin
        repeat ($urandom_range(3)) @(posedge clk_i);
        wr_done_o <= 1'b1;
        wr_exc_o <= wr_addr_i[15:12] == 4'hE ? 8'h04 : 8'h00;
        @(posedge clk_i);
        wr_done_o <= 1'b0;
        wr_exc_o <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/mbw_handler_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mbw_handler_tb_top;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic rx_valid_i = 1'b0;
  logic [7:0] rx_data_i = 8'h00;
  logic rx_last_i = 1'b0;
  logic rx_err_i = 1'b0;
  logic tx_ready_i = 1'b0;
  logic tx_valid_o, tx_last_o, wr_req_o, wr_save_o, wr_done_i, run_lock_i;
  logic [7:0] tx_data_o, wr_exc_i;
  logic [15:0] wr_addr_o, wr_data_o, err_cnt_o, d;
  logic [8:0] txq[$];
  logic [32:0] wq[$];
  int n_mismatch = 0;
  int checks_done = 0;
  int n_ans = 0;
  always #25 clk_i = ~clk_i;
  mbw_handler dut (.clk_i, .nrst_i, .rx_valid_i, .rx_data_i, .rx_last_i, .rx_err_i,
    .tx_valid_o, .tx_data_o, .tx_last_o, .tx_ready_i, .wr_req_o, .wr_addr_o, .wr_data_o,
    .wr_save_o, .wr_done_i, .wr_exc_i, .run_lock_i, .err_cnt_o);
  mbw_app_model u_app (.clk_i, .wr_req_i(wr_req_o), .wr_addr_i(wr_addr_o),
    .wr_save_i(wr_save_o), .wr_done_o(wr_done_i), .wr_exc_o(wr_exc_i),
    .run_lock_o(run_lock_i));
  // A sink that stalls at random exercises the hold of the answer bytes that it stalls on.
  always @(posedge clk_i) tx_ready_i <= $urandom_range(1) != 0;
  task automatic chk(input string w, input logic [32:0] e, input logic [32:0] s);
    checks_done++;
    if (e !== s) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", w, e, s);
    end
  endtask
  always @(posedge clk_i) begin
    if (tx_valid_o && tx_ready_i) begin
      chk("answer", txq.size() ? txq.pop_front() : 'x, {tx_last_o, tx_data_o});
      if (tx_last_o) n_ans <= n_ans + 1;
    end
    if (wr_req_o && wr_done_i)
      chk("write", wq.size() ? wq.pop_front() : 'x, {wr_addr_o, wr_data_o, wr_save_o});
  end
  task automatic ex(input logic [7:0] b[$]);
    foreach (b[i]) txq.push_back({i == b.size() - 1, b[i]});
  endtask
  // The next request waits for the last answer byte, as the handler requires.
  task automatic send(input logic [7:0] b[$]);
    int k;
    k = n_ans;
    foreach (b[i]) begin
      rx_valid_i <= 1'b1;
      rx_data_i <= b[i];
      rx_last_i <= i == b.size() - 1;
      @(posedge clk_i);
    end
    rx_valid_i <= 1'b0;
    rx_last_i <= 1'b0;
    repeat (400) if (n_ans == k) @(posedge clk_i);
  endtask
  task automatic one(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] v,
    input logic [7:0] e);
    if (e == 8'h00) ex('{fc, a[15:8], a[7:0], v[15:8], v[7:0]});
    else ex('{fc | 8'h80, e});
    if (fc != 8'h08 && e != 8'h01) wq.push_back({a, v, fc == 8'h06});
    send('{fc, a[15:8], a[7:0], v[15:8], v[7:0]});
  endtask
  task automatic blk(input logic [15:0] a, input logic [15:0] n, input logic [7:0] bc,
    input int nw);
    logic [7:0] b[$];
    logic [15:0] v;
    logic ok;
    ok = n >= 16'h0001 && n <= 16'h0010 && {8'h00, bc} == n << 1;
    b = '{8'h10, a[15:8], a[7:0], n[15:8], n[7:0], bc};
    for (int i = 0; i < nw; i++) begin
      v = 16'($urandom);
      b.push_back(v[15:8]);
      b.push_back(v[7:0]);
      if (ok) wq.push_back({a + 16'(i), v, 1'b1});
    end
    if (ok) ex('{8'h10, a[15:8], a[7:0], n[15:8], n[7:0]});
    else ex('{8'h90, 8'h03});
    send(b);
  endtask
  task automatic end_sim;
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h7BEA));
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    rx_err_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rx_err_i <= 1'b0;
    @(posedge clk_i);
    chk("error count", 16'h0002, err_cnt_o);
    one(8'h08, 16'h000A, 16'h1234, 8'h00);
    chk("error count", 16'h0000, err_cnt_o);
    one(8'h08, 16'h0000, 16'hA537, 8'h00);
    one(8'h08, 16'h0001, 16'h0000, 8'h01);
    one(8'h03, 16'h0000, 16'h0001, 8'h01);
    one(8'h06, 16'h0001, 16'h0001, 8'h00);
    one(8'h06, 16'hE001, 16'h0005, 8'h04);
    one(8'h41, 16'hF007, 16'h1388, 8'h01);
    one(8'h06, 16'hF007, 16'h1388, 8'h00);
    repeat (4) begin
      d = 16'($urandom);
      one(8'h08, 16'h0000, d, 8'h00);
      one(8'h41, 16'($urandom_range(16'h6FFF)), d, 8'h00);
    end
    blk(16'h0300, 16'h0001, 8'h02, 1);
    blk(16'($urandom_range(16'h6FFF)), 16'h0010, 8'h20, 16);
    blk(16'h0300, 16'h0002, 8'h04, 2);
    blk(16'h0300, 16'h0000, 8'h00, 0);
    blk(16'h0300, 16'h0011, 8'h22, 17);
    blk(16'h0300, 16'h0002, 8'h03, 2);
    // A reset in mid-run must clear the counter and leave the handler ready for a request.
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("reset count", 16'h0000, err_cnt_o);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    one(8'h08, 16'h0000, 16'h5AC3, 8'h00);
    chk("leftover", 33'h0, 33'(txq.size() + wq.size()));
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    end_sim;
  end
endmodule
`default_nettype wire
